// ==== hdl/pil_pkg.sv ====
package pil_pkg;
    // Address and data widths of the board link
    localparam int ADDR_W        = 15;
    localparam int DATA_W        = 16;
    localparam int LEVEL_W       = 4;
    // Status word field positions
    localparam int ST_MAP_BIT    = 8;
    localparam int ST_MASK_LO    = 12;
    localparam int ST_MASK_HI    = 15;
    // Serial address field inside the address bus (bit 0 is MSB side)
    localparam int SER_ADDR_W    = 12;
    // Word address step for the next fetch: byte step 2 is one word
    localparam logic [15:0] FETCH_STEP_BYTES = 16'h0002;
    // Rates
    localparam int CLK_MHZ       = 100;
    localparam int FAST_MHZ      = 4;
    localparam int SLOW_MHZ      = 1;
    localparam int FAST_DIV      = CLK_MHZ / FAST_MHZ;
    localparam int SLOW_DIV      = CLK_MHZ / SLOW_MHZ;
    // Serial transfer limits
    localparam int BYTE_BITS     = 8;
    localparam int WORD_BITS     = 16;
    // Reset values
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'hf;

    // Processor operation codes offered on the command port
    typedef enum logic [2:0] {
        PIL_OP_FETCH  = 3'b000,
        PIL_OP_READ   = 3'b001,
        PIL_OP_WRITE  = 3'b010,
        PIL_OP_RTM    = 3'b011,
        PIL_OP_LDSER  = 3'b100,
        PIL_OP_STSER  = 3'b101,
        PIL_OP_SETBIT = 3'b110,
        PIL_OP_TSTBIT = 3'b111
    } pil_op_e;
endpackage : pil_pkg

// ==== hdl/pil_rate_div.sv ====
`timescale 1ns/1ns
// One-cycle enable every DIV clocks
module pil_rate_div #(
    parameter int DIV = 25
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Control
    input  wire logic restart,
    output logic      tick
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    wire           at_end = (cnt_reg == CW'(DIV - 1));

    initial begin
        if (DIV < 1) $error("pil_rate_div: DIV must be at least 1");
    end

    assign cnt_next = (restart || at_end) ? '0 : cnt_reg + CW'(1);
    assign tick     = at_end && !restart;

    // Free running count, restarted when a command is taken
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : pil_rate_div

// ==== hdl/pil_link.sv ====
`timescale 1ns/1ns
module pil_link
    import pil_pkg::*;
#(
    parameter int FAST_DIVIDE = FAST_DIV,
    parameter int SLOW_DIVIDE = SLOW_DIV
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Processor command port
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_data,
    input  wire logic [4:0]        cmd_count,
    input  wire logic              cmd_ext_op,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_ext_trap,
    // Status word from the processor
    input  wire logic [DATA_W-1:0] status_word,
    // Memory cycle side
    output logic                   cycle_request,
    output logic                   write_qual,
    output logic                   bus_hold,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    input  wire logic [DATA_W-1:0] mem_rdata,
    input  wire logic              mem_grant,
    output logic                   fetch_indicator,
    output logic                   map_select_n,
    output logic                   end_of_instruction_n,
    // Interrupt side
    input  wire logic              interrupt_present,
    input  wire logic [3:0]        level_code,
    output logic                   int_start,
    output logic [LEVEL_W-1:0]     int_level,
    // Serial bus
    output logic                   serial_out_strobe_enable,
    output logic                   serial_bit_out,
    input  wire logic              serial_bit_in,
    input  wire logic              local_chassis_n,
    // Extended operation handshake
    input  wire logic              module_present,
    input  wire logic              module_done,
    input  wire logic              module_abort,
    input  wire logic              breakpoint_n,
    output logic                   bp_stop
);
    initial begin
        if (FAST_DIVIDE < 1 || SLOW_DIVIDE < FAST_DIVIDE)
            $error("pil_link: bad serial rate divide");
    end

    typedef enum logic [2:0] {
        PIL_IDLE   = 3'b000,
        PIL_MEM    = 3'b001,
        PIL_RMW_WR = 3'b010,
        PIL_SER    = 3'b011,
        PIL_EXT    = 3'b100,
        PIL_DONE   = 3'b101
    } pil_state_e;

    pil_state_e           state_reg, state_next;
    logic [2:0]           op_reg;
    logic [ADDR_W-1:0]    addr_reg;
    logic [DATA_W-1:0]    data_reg;
    logic [4:0]           cnt_reg;
    logic [4:0]           total_reg;
    logic [LEVEL_W-1:0]   code_reg;
    logic                 ext_reg;
    logic                 trap_reg;

    // Decode of the operation in hand; a new command counts from its take
    // edge so the first cycle of a request never shows old qualifiers
    wire              take     = cmd_valid && (state_reg == PIL_IDLE);
    wire [2:0]        op_now   = take ? cmd_op : op_reg;
    wire [ADDR_W-1:0] addr_now = take ? cmd_addr : addr_reg;
    wire [DATA_W-1:0] data_now = take ? cmd_data : data_reg;
    wire is_write  = (op_now == PIL_OP_WRITE);
    wire is_fetch  = (op_now == PIL_OP_FETCH);
    wire is_rtm    = (op_now == PIL_OP_RTM);
    wire is_ser_in = (op_now == PIL_OP_STSER) || (op_now == PIL_OP_TSTBIT);
    wire ser_last  = (cnt_reg + 5'd1 >= total_reg);
    wire [3:0] mask = status_word[ST_MASK_HI:ST_MASK_LO];
    wire int_ok    = interrupt_present && (code_reg <= mask);
    // Next fetch address: word bus, byte step of 2 is one word
    wire [ADDR_W-1:0] next_fetch = addr_reg +
                                   ADDR_W'(FETCH_STEP_BYTES >> 1);

    // Serial bit pacing; main chassis input runs fast
    logic fast_tick;
    logic slow_tick;
    logic ser_restart;
    assign ser_restart = take;
    pil_rate_div #(.DIV(FAST_DIVIDE)) u_fast (
        .clock   (clock),
        .rst_n   (rst_n),
        .restart (ser_restart),
        .tick    (fast_tick)
    );
    pil_rate_div #(.DIV(SLOW_DIVIDE)) u_slow (
        .clock   (clock),
        .rst_n   (rst_n),
        .restart (ser_restart),
        .tick    (slow_tick)
    );
    // Only input bits get the fast path; output keeps the slow rate
    wire bit_tick = (is_ser_in && !local_chassis_n) ? fast_tick
                                                   : slow_tick;

    // Right-justify stored bits, upper bits zero; first bit lands in LSB
    logic [DATA_W-1:0] packed_in;
    always_comb begin
        packed_in = data_reg >> (5'd16 - total_reg);
        if (total_reg <= 5'(BYTE_BITS))
            packed_in = {8'h00, packed_in[7:0]};
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PIL_IDLE: begin
                if (take) begin
                    if (cmd_ext_op)
                        state_next = PIL_EXT;
                    else if (cmd_op[2])
                        state_next = PIL_SER;
                    else
                        state_next = PIL_MEM;
                end
            end
            PIL_MEM: begin
                if (mem_grant)  // bus may be stolen; wait
                    state_next = is_rtm ? PIL_RMW_WR : PIL_DONE;
            end
            PIL_RMW_WR: begin
                if (mem_grant)
                    state_next = PIL_DONE;
            end
            PIL_SER: begin
                if (bit_tick && ser_last)
                    state_next = PIL_DONE;
            end
            PIL_EXT: begin
                if (!module_present || module_done)
                    state_next = PIL_DONE;
            end
            PIL_DONE: state_next = PIL_IDLE;
            default:  state_next = PIL_IDLE;
        endcase
    end

    // Command capture and sequencing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= PIL_IDLE;
            op_reg    <= 3'h0;
            addr_reg  <= '0;
            data_reg  <= '0;
            cnt_reg   <= 5'h0;
            total_reg <= 5'h0;
            ext_reg   <= 1'b0;
            trap_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take) begin
                op_reg    <= cmd_op;
                addr_reg  <= cmd_addr;
                data_reg  <= cmd_data;
                cnt_reg   <= 5'h0;
                total_reg <= (cmd_op == PIL_OP_SETBIT ||
                              cmd_op == PIL_OP_TSTBIT) ? 5'd1 :
                             (cmd_count == 5'h0) ? 5'd16 : cmd_count;
                ext_reg   <= cmd_ext_op;
                trap_reg  <= 1'b0;
            end else if (state_reg == PIL_SER && bit_tick) begin
                cnt_reg <= cnt_reg + 5'd1;
                if (is_ser_in)
                    data_reg <= {serial_bit_in, data_reg[DATA_W-1:1]};
                else
                    data_reg <= {1'b0, data_reg[DATA_W-1:1]};
            end else if (state_reg == PIL_MEM && mem_grant && !is_write) begin
                data_reg <= mem_rdata;
                if (is_fetch)
                    addr_reg <= next_fetch;
            end else if (state_reg == PIL_EXT &&
                         (!module_present || module_abort)) begin
                // Kept to the answer; abort may drop before done does
                trap_reg <= 1'b1;
            end
        end
    end

    // Interrupt code register resampled while request stands
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            code_reg  <= LEVEL_RESET;
            int_start <= 1'b0;
            int_level <= LEVEL_RESET;
        end else begin
            if (interrupt_present)
                code_reg <= level_code;
            // Failed compare simply yields no start pulse
            int_start <= int_ok && (state_reg == PIL_IDLE);
            if (int_ok)
                int_level <= code_reg;
        end
    end

    // Link outputs, all registered
    wire mem_phase = (state_next == PIL_MEM) || (state_next == PIL_RMW_WR);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cycle_request            <= 1'b0;
            write_qual               <= 1'b0;
            bus_hold                 <= 1'b0;
            mem_addr                 <= '0;
            mem_wdata                <= '0;
            fetch_indicator          <= 1'b0;
            map_select_n             <= 1'b1;
            end_of_instruction_n     <= 1'b1;
            serial_out_strobe_enable <= 1'b0;
            serial_bit_out           <= 1'b0;
            cmd_ready                <= 1'b0;
            rsp_valid                <= 1'b0;
            rsp_data                 <= '0;
            rsp_ext_trap             <= 1'b0;
            bp_stop                  <= 1'b0;
        end else begin
            cycle_request <= mem_phase;
            write_qual    <= (state_next == PIL_RMW_WR) ||
                             (mem_phase && is_write);
            // Held from read through rewrite, dropped when done
            bus_hold      <= mem_phase && is_rtm;
            mem_addr      <= addr_now;
            mem_wdata     <= data_now;
            fetch_indicator <= mem_phase && is_fetch;
            map_select_n  <= !status_word[ST_MAP_BIT];
            end_of_instruction_n <= !(state_next == PIL_DONE);
            serial_out_strobe_enable <= (state_reg == PIL_SER) &&
                                        !is_ser_in && bit_tick;
            if (state_reg == PIL_SER && !is_ser_in)
                serial_bit_out <= data_reg[0];
            cmd_ready <= (state_next == PIL_IDLE);
            rsp_valid <= (state_reg == PIL_DONE);
            if (state_reg == PIL_DONE) begin
                rsp_data     <= is_ser_in ? packed_in : data_reg;
                rsp_ext_trap <= ext_reg && trap_reg;
            end
            bp_stop <= !breakpoint_n;
        end
    end

endmodule : pil_link

// ==== testbench/pil_link_assertions.sv ====
`timescale 1ns/1ns
// Timing relations on the processor side of the board link
module pil_link_checker
    import pil_pkg::*;
(
    // Clock and reset
    input wire logic               clock,
    input wire logic               rst_n,
    // Command port
    input wire logic               cmd_ready,
    input wire logic               rsp_valid,
    input wire logic [DATA_W-1:0]  status_word,
    // Memory cycle side
    input wire logic               cycle_request,
    input wire logic               write_qual,
    input wire logic               bus_hold,
    input wire logic               fetch_indicator,
    input wire logic               map_select_n,
    input wire logic               end_of_instruction_n,
    // Interrupt and serial side
    input wire logic               int_start,
    input wire logic [LEVEL_W-1:0] int_level,
    input wire logic               serial_out_strobe_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Map select follows status bit 8 one cycle later
    property p_map;
        $past(rst_n) |-> map_select_n == !$past(status_word[ST_MAP_BIT]);
    endproperty
    a_map: assert property (p_map)
        else $error("map select does not follow status bit");
    property p_wq;
        write_qual |-> cycle_request;
    endproperty
    a_wq: assert property (p_wq)
        else $error("write qualifier without a cycle request");
    property p_req;
        cycle_request |-> !cmd_ready;
    endproperty
    a_req: assert property (p_req)
        else $error("cycle request while idle");
    property p_hold;
        bus_hold |-> !cmd_ready;
    endproperty
    a_hold: assert property (p_hold)
        else $error("bus hold while idle");
    // Hold opens on the read half and closes right after the rewrite
    property p_hold_rd;
        $rose(bus_hold) |-> cycle_request && !write_qual;
    endproperty
    a_hold_rd: assert property (p_hold_rd)
        else $error("bus hold did not open on the read");
    property p_hold_rel;
        $fell(bus_hold) |-> $past(write_qual) && !cycle_request;
    endproperty
    a_hold_rel: assert property (p_hold_rel)
        else $error("bus hold not released after the rewrite");
    // Accepted level never above the mask
    property p_int;
        int_start |-> int_level <= $past(status_word[ST_MASK_HI:ST_MASK_LO]);
    endproperty
    a_int: assert property (p_int)
        else $error("interrupt started above the mask");
    property p_eoi;
        !end_of_instruction_n |=> rsp_valid && end_of_instruction_n;
    endproperty
    a_eoi: assert property (p_eoi)
        else $error("final state not one cycle before the answer");
    property p_strobe;
        serial_out_strobe_enable |-> !cmd_ready;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("serial strobe while idle");
    property p_fetch;
        fetch_indicator |-> cycle_request && !write_qual;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch indicator outside a read cycle");
endmodule : pil_link_checker

bind pil_link pil_link_checker chk_u (.*);

// ==== testbench/pil_board_model.sv ====
`timescale 1ns/1ns
// Interface board stand-in: memory, serial input, module handshake
module pil_board_model
    import pil_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Memory side
    input  wire logic              cycle_request,
    input  wire logic              write_qual,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_wdata,
    output logic      [DATA_W-1:0] mem_rdata,
    output logic                   mem_grant,
    // Scenario controls
    input  wire logic [3:0]        grant_wait,
    input  wire logic              ser_level,
    input  wire logic [1:0]        ext_mode,
    // Serial and module lines
    output logic                   serial_bit_in,
    output logic                   module_present,
    output logic                   module_done,
    output logic                   module_abort
);
    logic [DATA_W-1:0] mem [0:255];
    logic [3:0]        wait_reg;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'(i) ^ 16'h5a00;
        end
    end
    // Other masters win first, so the grant comes late
    always @(posedge clock) begin
        if (!rst_n || !cycle_request || mem_grant) begin
            wait_reg  <= 4'h0;
            mem_grant <= 1'b0;
        end else begin
            wait_reg  <= wait_reg + 4'h1;
            mem_grant <= (wait_reg >= grant_wait);
        end
        if (mem_grant && write_qual) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
    end
    // Data lines invert outside a grant so stale values never match
    assign mem_rdata      = mem_grant ? mem[mem_addr[7:0]]
                                      : ~mem[mem_addr[7:0]];
    // Every serial address decodes to one stand-in slot
    assign serial_bit_in  = ser_level;
    assign module_present = ext_mode[0];
    assign module_done    = ext_mode[0];
    assign module_abort   = &ext_mode;
endmodule : pil_board_model

// ==== testbench/tb_processor_interface_board_link.sv ====
`timescale 1ns/1ns
// Self-checking bench for the processor side of the board link
module tb_processor_interface_board_link;
    import pil_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
    logic        cmd_ext_op = 1'b0, interrupt_present = 1'b0;
    logic        local_chassis_n = 1'b1, breakpoint_n = 1'b1;
    logic        ser_level = 1'b0;
    logic [2:0]  cmd_op = 3'h0;
    logic [14:0] cmd_addr = 15'h0;
    logic [15:0] cmd_data = 16'h0, status_word = 16'h0, out_bits;
    logic [4:0]  cmd_count = 5'h0;
    logic [3:0]  level_code = 4'hf, grant_wait = 4'h1, int_level;
    logic [1:0]  ext_mode = 2'h0;
    logic [15:0] rsp_data, mem_wdata, mem_rdata;
    logic [14:0] mem_addr;
    logic        cmd_ready, rsp_valid, rsp_ext_trap, cycle_request;
    logic        write_qual, bus_hold, mem_grant, fetch_indicator;
    logic        map_select_n, end_of_instruction_n, int_start, bp_stop;
    logic        serial_out_strobe_enable, serial_bit_out, serial_bit_in;
    logic        module_present, module_done, module_abort;
    int          errors = 0, compares = 0, cycles = 0, n_out = 0, n_int = 0;
    int          seed = 32'h4df5;
    int          lat = 0;
    localparam int FAST_D = 2;
    localparam int SLOW_D = 4;
    logic [4:0]  cnt_tab [4] = '{5'd1, 5'd8, 5'd9, 5'd0};

    // Small dividers keep serial transfers short
    pil_link #(.FAST_DIVIDE(FAST_D), .SLOW_DIVIDE(SLOW_D)) dut_u (.*);
    pil_board_model board_u (.*);

    always #5 clock = ~clock;

    // Output bits collected LSB first; hang guard
    always @(posedge clock) begin
        cycles++;
        if (serial_out_strobe_enable) begin
            out_bits <= {serial_bit_out, out_bits[15:1]};
            n_out    <= n_out + 1;
        end
        if (int_start) n_int <= n_int + 1;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_bit(input logic got, input logic exp);
        chk_data({15'h0, got}, {15'h0, exp});
    endtask : chk_bit

    // Request held until taken, then wait for the answer pulse
    task automatic run(input logic [2:0] op, input logic [14:0] a,
                       input logic [15:0] d, input logic [4:0] n,
                       input logic x);
        int t;
        @(posedge clock);
        cmd_valid  <= 1'b1;
        cmd_op     <= op;
        cmd_addr   <= a;
        cmd_data   <= d;
        cmd_count  <= n;
        cmd_ext_op <= x;
        t = 0;
        do @(posedge clock); while (cmd_ready !== 1'b1 && t++ < 500);
        cmd_valid <= 1'b0;
        t = 0;
        do @(posedge clock); while (rsp_valid !== 1'b1 && t++ < 500);
        lat = t + 1;
        chk_bit(rsp_valid, 1'b1);
    endtask : run

    // Right-justified, zero-filled serial result
    function automatic logic [15:0] exp_in(input logic [4:0] n,
                                           input logic v);
        int k;
        k = (n == 5'h0) ? 16 : int'(n);
        return v ? 16'((17'h1 << k) - 17'h1) : 16'h0;
    endfunction : exp_in

    // Serial answer time: one divider period per bit plus two edges
    function automatic logic [15:0] exp_lat(input logic [4:0] n,
                                            input int div);
        int k;
        k = (n == 5'h0) ? 16 : int'(n);
        return 16'(k * div + 2);
    endfunction : exp_lat

    task automatic finish_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    initial begin
        logic [14:0] a;
        logic [15:0] d;
        logic [4:0]  n;
        int          n0, k;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk_bit(map_select_n, 1'b1);
        chk_bit(end_of_instruction_n, 1'b1);
        chk_data({12'h0, int_level}, 16'h000f);
        // Random write then read back, grant delayed and status varied
        for (int i = 0; i < 16; i++) begin
            a = 15'($random(seed));
            d = 16'($random(seed));
            status_word <= 16'($random(seed));
            grant_wait  <= 4'($random(seed));
            run(PIL_OP_WRITE, a, d, 5'h0, 1'b0);
            run(PIL_OP_READ, a, 16'h0, 5'h0, 1'b0);
            chk_data(rsp_data, d);
        end
        run(PIL_OP_FETCH, a, 16'h0, 5'h0, 1'b0);
        chk_data(rsp_data, d);
        chk_data({1'b0, mem_addr},
                 {1'b0, a + 15'(FETCH_STEP_BYTES >> 1)});
        run(PIL_OP_RTM, a, 16'h0, 5'h0, 1'b0);
        chk_data(rsp_data, d);
        // Serial input at both rates, byte and word boundaries
        for (int i = 0; i < 8; i++) begin
            ser_level       <= i[2];
            local_chassis_n <= i[0];
            run(PIL_OP_STSER, a, 16'h0, cnt_tab[i % 4], 1'b0);
            chk_data(rsp_data, exp_in(cnt_tab[i % 4], i[2]));
            chk_data(16'(lat),
                     exp_lat(cnt_tab[i % 4], i[0] ? SLOW_D : FAST_D));
            run(PIL_OP_TSTBIT, a, 16'h0, 5'h1, 1'b0);
            chk_data(rsp_data, {15'h0, ser_level});
        end
        // Serial output, last entry a single set-bit
        for (int i = 0; i < 5; i++) begin
            d = 16'($random(seed));
            n = (i == 4) ? 5'h1 : cnt_tab[i];
            n0 = n_out;
            run((i == 4) ? PIL_OP_SETBIT : PIL_OP_LDSER, a, d, n, 1'b0);
            k = (n == 5'h0) ? 16 : int'(n);
            chk_data(16'(n_out - n0), 16'(k));
            chk_data(out_bits >> (16 - k), d & exp_in(n, 1'b1));
        end
        // Absent, present, aborted module
        for (int i = 0; i < 3; i++) begin
            ext_mode <= 2'(i | (i >> 1));
            run(PIL_OP_READ, a, 16'h0, 5'h0, 1'b1);
            chk_bit(rsp_ext_trap, i != 1);
        end
        // Level 7 refused under mask 5, taken once mask is 7
        status_word       <= 16'h5000;
        level_code        <= 4'h7;
        interrupt_present <= 1'b1;
        n0 = n_int;
        repeat (30) @(posedge clock);
        chk_data(16'(n_int - n0), 16'h0);
        status_word <= 16'h7000;
        repeat (30) @(posedge clock);
        chk_bit(n_int > n0, 1'b1);
        chk_data({12'h0, int_level}, 16'h0007);
        interrupt_present <= 1'b0;
        breakpoint_n      <= 1'b0;
        repeat (3) @(posedge clock);
        chk_bit(bp_stop, 1'b1);
        breakpoint_n <= 1'b1;
        repeat (2) @(posedge clock);
        chk_bit(bp_stop, 1'b0);
        finish_test();
    end
endmodule : tb_processor_interface_board_link
